// ===== rtl/mci_pkg.sv
/*
 * Shared constants and types of the modem command interpreter: character
 * codes, command line layout, result codes, response text and states.
 * Assumes 8-bit characters on the payload port and 5-digit unit addresses.
 */
package mci_pkg;

    localparam int CHAR_W = 8;
    localparam int ADDR_W = 17;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------------
    // character codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CHR_A = 8'h41;
    localparam logic [7:0] CHR_T = 8'h54;
    localparam logic [7:0] CHR_D = 8'h44;
    localparam logic [7:0] CHR_H = 8'h48;
    localparam logic [7:0] CHR_V = 8'h56;
    localparam logic [7:0] CHR_0 = 8'h30;
    localparam logic [7:0] CHR_1 = 8'h31;
    localparam logic [7:0] CHR_9 = 8'h39;
    localparam logic [7:0] CHR_PLUS = 8'h2B;
    localparam logic [7:0] CHR_CR = 8'h0D;

    // ------------------------------------------------------------------
    // command line layout
    // ------------------------------------------------------------------
    localparam int POS_CMD = 2;
    localparam int POS_ARG = 3;
    localparam int POS_DIG = 4;
    localparam int DIAL_DIGITS = 5;
    localparam int LINE_MAX = 9;
    localparam logic [3:0] LEN_PREFIX = 4'h2;
    localparam logic [3:0] LEN_HANG = 4'h3;
    localparam logic [3:0] LEN_VERB = 4'h4;
    localparam logic [3:0] LEN_DIAL = 4'h9;
    localparam logic [3:0] LEN_SAT = 4'hF;
    localparam logic [3:0] LEN_LIMIT = 4'h9;
    localparam logic [1:0] ESC_LAST = 2'h2;

    localparam logic [16:0] DEC_1 = 17'h0_0001;
    localparam logic [16:0] DEC_10 = 17'h0_000A;
    localparam logic [16:0] DEC_100 = 17'h0_0064;
    localparam logic [16:0] DEC_1K = 17'h0_03E8;
    localparam logic [16:0] DEC_10K = 17'h0_2710;

    // ------------------------------------------------------------------
    // results and their text, left aligned, ended by carriage return
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_OK = 8'h00;
    localparam logic [7:0] CODE_CONNECT = 8'h01;
    localparam logic [7:0] CODE_ERROR = 8'h04;
    localparam logic [63:0] TXT_OK = 64'h4F4B_0D00_0000_0000;
    localparam logic [63:0] TXT_CONNECT = 64'h434F_4E4E_4543_540D;
    localparam logic [63:0] TXT_ERROR = 64'h4552_524F_520D_0000;

    typedef enum logic [1:0] {ST_CMD, ST_RESP, ST_PASS} mci_state_type;
    typedef enum logic [1:0] {RES_OK, RES_CONNECT, RES_ERROR} mci_result_type;

    typedef struct packed {
        logic [ADDR_W-1:0] src;
        logic [CHAR_W-1:0] data;
    } mci_remote_char_type;

endpackage

// ===== rtl/mci_top.sv
/*
 * Modem command interpreter on the master's payload port, with the
 * 16-word link FIFO toward the radio network.
 * Assumes one 125 MHz clock, inputs synchronous to it, and a network
 * side that answers address presence within the same cycle.
 */
// Operation
// - only master with emulation enabled interprets commands
// - scan payload port only; dial is payload
// - bare AT answers OK, code 0
// - dial takes five digits, answers CONNECT
// - known address opens link, becomes addressed station
// - open link forwards characters until +++
// - link held until +++, hang-up, late AT or raw mode
// - hang-up or +++ drops link, answers OK
// - ATV0 numeric, ATV1 text, text default
// - bad AT command answers ERROR, code 4
// - non-command characters echoed, otherwise ignored
// - late AT in junk closes link
// - only addressed remote exchanges payload; any remote in raw mode
// - dial acknowledged locally, no reachability check
// - poll simulator idle unless link open or interpreter inactive (raw)
// - diagnostics unaffected by link state
`timescale 1ns/1ps

module mci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire do_wr = in_valid && !full;
    wire do_rd = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW + 1)'(do_wr);
            rd_ptr <= rd_ptr + (AW + 1)'(do_rd);
        end
    end
endmodule // mci_fifo

module mci_top
    import mci_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic is_master,
    input wire logic dialup_emulation_enable,
    input wire logic host_in_valid,
    output logic host_in_ready,
    input wire logic [CHAR_W-1:0] host_in_data,
    output logic host_out_valid,
    input wire logic host_out_ready,
    output logic [CHAR_W-1:0] host_out_data,
    output logic link_out_valid,
    input wire logic link_out_ready,
    output logic [CHAR_W-1:0] link_out_data,
    input wire logic link_in_valid,
    output logic link_in_ready,
    input wire mci_remote_char_type link_in,
    output logic [ADDR_W-1:0] dial_query_addr,
    input wire logic dial_addr_present,
    output logic link_open,
    output logic [ADDR_W-1:0] link_addr,
    output logic rtu_poll_enable
);
    mci_state_type st;
    mci_result_type resp_code;
    logic [7:0] line_buf [0:LINE_MAX-1];
    logic [3:0] line_len;
    logic prev_a;
    logic verbose;
    logic [2:0] resp_idx;
    logic resp_to_pass;
    logic [1:0] plus_cnt;
    logic [1:0] flush_cnt;
    logic hold_valid;
    logic [7:0] hold_data;

    // ------------------------------------------------------------------
    // mode and command decode
    // ------------------------------------------------------------------
    wire active = is_master && dialup_emulation_enable;
    wire raw = !active;
    wire out_free = !host_out_valid || host_out_ready;
    wire in_plus = (host_in_data == CHR_PLUS);
    wire cmd_take = active && (st == ST_CMD) && host_in_valid && out_free;
    wire line_end = cmd_take && (host_in_data == CHR_CR);

    wire is_at = (line_len >= LEN_PREFIX) && (line_buf[0] == CHR_A) && (line_buf[1] == CHR_T);
    wire cmd_bare = is_at && (line_len == LEN_PREFIX);
    wire cmd_hang = is_at && (line_len == LEN_HANG) && (line_buf[POS_CMD] == CHR_H);
    wire verb_arg_ok = (line_buf[POS_ARG] == CHR_0) || (line_buf[POS_ARG] == CHR_1);
    wire cmd_verb = is_at && (line_len == LEN_VERB) && (line_buf[POS_CMD] == CHR_V) && verb_arg_ok;
    logic [DIAL_DIGITS-1:0] dig_ok;
    logic [3:0] dig [0:DIAL_DIGITS-1];
    for (genvar i = 0; i < DIAL_DIGITS; i++) begin : g_dig
        assign dig_ok[i] = (line_buf[POS_DIG+i] >= CHR_0) && (line_buf[POS_DIG+i] <= CHR_9);
        assign dig[i] = 4'(line_buf[POS_DIG+i] - CHR_0);
    end
    wire dial_prefix = (line_buf[POS_CMD] == CHR_D) && (line_buf[POS_ARG] == CHR_T);
    wire cmd_dial = is_at && (line_len == LEN_DIAL) && dial_prefix && (&dig_ok);
    wire cmd_valid = cmd_bare || cmd_hang || cmd_verb || cmd_dial;
    wire late_at = cmd_take && prev_a && (host_in_data == CHR_T) && (line_len > LEN_PREFIX) && !is_at;

    assign dial_query_addr = 17'(dig[0]) * DEC_10K + 17'(dig[1]) * DEC_1K + 17'(dig[2]) * DEC_100
        + 17'(dig[3]) * DEC_10 + 17'(dig[4]) * DEC_1;

    // ------------------------------------------------------------------
    // passthrough and escape holdback
    // ------------------------------------------------------------------
    logic fifo_in_ready;
    wire pass_free = (flush_cnt == '0) && !hold_valid;
    wire pass_take = active && (st == ST_PASS) && host_in_valid && fifo_in_ready && pass_free;
    wire esc_hit = pass_take && in_plus && (plus_cnt == ESC_LAST);
    wire pass_direct = pass_take && !in_plus && (plus_cnt == '0);
    // held pluses go out before the character that broke the run
    wire pass_push = (st == ST_PASS) && ((flush_cnt != '0) || hold_valid || pass_direct);
    wire [7:0] pass_data = (flush_cnt != '0) ? CHR_PLUS : (hold_valid ? hold_data : host_in_data);
    wire fifo_wvalid = raw ? host_in_valid : (active && pass_push);
    wire [7:0] fifo_wdata = raw ? host_in_data : pass_data;
    wire pass_ready = (st == ST_PASS) && fifo_in_ready && pass_free;

    assign host_in_ready = raw ? fifo_in_ready : (((st == ST_CMD) && out_free) || pass_ready);

    mci_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_wvalid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_wdata),
        .out_valid(link_out_valid),
        .out_ready(link_out_ready),
        .out_data(link_out_data)
    );

    // ------------------------------------------------------------------
    // responses and host output
    // ------------------------------------------------------------------
    function automatic logic [7:0] resp_char(mci_result_type code, logic [2:0] idx, logic text);
        logic [63:0] txt;
        logic [7:0] num;
        txt = TXT_ERROR;
        num = CODE_ERROR;
        if (code == RES_OK) begin
            txt = TXT_OK;
            num = CODE_OK;
        end else if (code == RES_CONNECT) begin
            txt = TXT_CONNECT;
            num = CODE_CONNECT;
        end
        if (text) begin
            resp_char = txt[63 - 8 * int'(idx) -: 8];
        end else begin
            resp_char = (idx == '0) ? 8'(CHR_0 + num) : CHR_CR;
        end
    endfunction

    wire [7:0] resp_ch = resp_char(resp_code, resp_idx, verbose);
    wire resp_step = (st == ST_RESP) && out_free;
    wire resp_last = resp_step && (resp_ch == CHR_CR);
    wire fwd_ok = raw || (link_open && (link_in.src == link_addr));
    wire sel_rem = link_in_valid && fwd_ok && out_free && !resp_step && !cmd_take;

    // unaddressed remote data is swallowed so it cannot block the port
    assign link_in_ready = sel_rem || (link_in_valid && !fwd_ok);
    assign rtu_poll_enable = raw || link_open;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_out_valid <= 1'b0;
            host_out_data <= '0;
        end else if (out_free) begin
            host_out_valid <= resp_step || cmd_take || sel_rem;
            if (resp_step) begin
                host_out_data <= resp_ch;
            end else if (cmd_take) begin
                host_out_data <= host_in_data;
            end else if (sel_rem) begin
                host_out_data <= link_in.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // command line capture
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (cmd_take && (line_len < LEN_LIMIT)) begin
            line_buf[line_len] <= host_in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_len <= '0;
            prev_a <= 1'b0;
        end else if (line_end || st != ST_CMD || raw) begin
            line_len <= '0;
            prev_a <= 1'b0;
        end else if (cmd_take) begin
            line_len <= (line_len == LEN_SAT) ? line_len : line_len + 4'h1;
            prev_a <= (host_in_data == CHR_A);
        end
    end

    // ------------------------------------------------------------------
    // sequencer and link state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= ST_CMD;
            resp_code <= RES_OK;
            resp_idx <= '0;
            resp_to_pass <= 1'b0;
        end else if (raw) begin
            st <= ST_CMD;
        end else if (line_end && (cmd_valid || is_at)) begin
            st <= ST_RESP;
            resp_idx <= '0;
            resp_to_pass <= cmd_dial && dial_addr_present;
            if (cmd_dial) begin
                resp_code <= RES_CONNECT;
            end else if (cmd_valid) begin
                resp_code <= RES_OK;
            end else begin
                resp_code <= RES_ERROR;
            end
        end else if (esc_hit) begin
            st <= ST_RESP;
            resp_idx <= '0;
            resp_to_pass <= 1'b0;
            resp_code <= RES_OK;
        end else if (resp_last) begin
            st <= resp_to_pass ? ST_PASS : ST_CMD;
        end else if (resp_step) begin
            resp_idx <= resp_idx + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_open <= 1'b0;
            link_addr <= '0;
            verbose <= 1'b1;
        end else if (raw) begin
            link_open <= 1'b0;
        end else if (line_end && cmd_dial && dial_addr_present) begin
            link_open <= 1'b1;
            link_addr <= dial_query_addr;
        end else if ((line_end && cmd_hang) || esc_hit || late_at) begin
            link_open <= 1'b0;
        end else if (line_end && cmd_verb) begin
            verbose <= (line_buf[POS_ARG] == CHR_1);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            plus_cnt <= '0;
            flush_cnt <= '0;
            hold_valid <= 1'b0;
            hold_data <= '0;
        end else if (raw || st != ST_PASS || esc_hit) begin
            plus_cnt <= '0;
            flush_cnt <= '0;
            hold_valid <= 1'b0;
        end else if (flush_cnt != '0) begin
            flush_cnt <= fifo_in_ready ? flush_cnt - 2'h1 : flush_cnt;
        end else if (hold_valid) begin
            hold_valid <= !fifo_in_ready;
        end else if (pass_take && in_plus) begin
            plus_cnt <= plus_cnt + 2'h1;
        end else if (pass_take && (plus_cnt != '0)) begin
            flush_cnt <= plus_cnt;
            hold_valid <= 1'b1;
            hold_data <= host_in_data;
            plus_cnt <= '0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    raw_passthru_a: assert property (raw && host_in_valid |-> fifo_wvalid && (fifo_wdata == host_in_data))
        else $error("inactive interpreter did not pass data through");
    bare_ok_a: assert property (line_end && cmd_bare |=> (st == ST_RESP) && (resp_code == RES_OK))
        else $error("bare attention did not answer OK");
    dial_connect_a: assert property (line_end && cmd_dial |=> (resp_code == RES_CONNECT))
        else $error("dial did not answer CONNECT");
    dial_open_a: assert property (line_end && cmd_dial && dial_addr_present
        |=> link_open && (link_addr == $past(dial_query_addr)))
        else $error("dial did not open link to address");
    escape_drop_a: assert property (esc_hit |=> !link_open && (resp_code == RES_OK) && (st == ST_RESP))
        else $error("escape did not drop link with OK");
    verb_set_a: assert property (line_end && cmd_verb
        |=> verbose == ($past(line_buf[POS_ARG]) == CHR_1))
        else $error("verbosity not set from argument");
    error_reply_a: assert property (line_end && is_at && !cmd_valid |=> (resp_code == RES_ERROR))
        else $error("bad command did not answer ERROR");
    remote_fwd_a: assert property (sel_rem && active |-> link_open ##1 host_out_data == $past(link_in.data))
        else $error("remote data forwarded without matching link");
    poll_gate_a: assert property (active && !link_open |-> !rtu_poll_enable)
        else $error("poll enabled without link");
    plus_hold_a: assert property (pass_take && in_plus |-> !fifo_wvalid)
        else $error("plus forwarded before escape decided");
    resp_end_a: assert property (resp_last |=> host_out_data == CHR_CR)
        else $error("response not ended by carriage return");

    dial_cover: cover property (line_end && cmd_dial && dial_addr_present ##[1:20] (st == ST_PASS));
    escape_cover: cover property (esc_hit ##[1:20] (st == ST_CMD));
    numeric_cover: cover property (!verbose && resp_last);
endmodule // mci_top

// ===== sim/mci_host_model.sv
/*
 * Host terminal model on the payload port: sends characters under the
 * valid/ready handshake and takes host output, promptly or with stalls.
 * Assumes the testbench seeds $urandom and calls the send tasks.
 */
`timescale 1ns/1ps

module mci_host_model
    import mci_pkg::*;
(
    input wire logic sys_clk,
    output logic host_in_valid,
    input wire logic host_in_ready,
    output logic [CHAR_W-1:0] host_in_data,
    output logic host_out_ready,
    input wire logic stall_en
);
    initial begin
        host_in_valid = 1'b0;
        host_in_data = 8'h00;
        host_out_ready = 1'b1;
    end

    // ------------------------------------------------------------------
    // output side: a slow host takes characters on random cycles
    // ------------------------------------------------------------------
    always begin
        @(posedge sys_clk);
        #1;
        host_out_ready = stall_en ? 1'($urandom % 2) : 1'b1;
    end

    // ------------------------------------------------------------------
    // input side
    // ------------------------------------------------------------------
    task automatic send_char(input logic [7:0] c);
        @(posedge sys_clk);
        #1;
        host_in_valid = 1'b1;
        host_in_data = c;
        do @(posedge sys_clk); while (host_in_ready !== 1'b1);
        #1;
        host_in_valid = 1'b0;
        // released data must not look like the last character
        host_in_data = ~c;
    endtask

    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            send_char(s[i]);
        end
    endtask

    // one unbroken string, closed by carriage return
    task automatic send_line(input string s);
        send_str(s);
        send_char(8'h0D);
    endtask
endmodule // mci_host_model

// ===== sim/mci_top_tb.sv
/*
 * Self-checking testbench of the modem command interpreter.
 * Assumes the host model beside it and a network side driven here.
 */
`timescale 1ns/1ps

module mci_top_tb
    import mci_pkg::*;
;
    logic sys_clk, sys_rst, is_master, dialup_emulation_enable, stall_en, lo_mode;
    logic host_in_valid, host_in_ready, host_out_valid, host_out_ready;
    logic [CHAR_W-1:0] host_in_data, host_out_data, link_out_data;
    logic link_out_valid, link_out_ready, link_in_valid, link_in_ready;
    mci_remote_char_type link_in;
    logic [ADDR_W-1:0] dial_query_addr, link_addr, known_addr;
    logic dial_addr_present, link_open, rtu_poll_enable;
    logic [7:0] exp_host[$], exp_link[$];
    int n_mismatch, checks_done, verb_num;
    string s;

    // network answers presence in the same cycle
    assign dial_addr_present = (dial_query_addr == known_addr);

    mci_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .is_master(is_master),
        .dialup_emulation_enable(dialup_emulation_enable), .host_in_valid(host_in_valid),
        .host_in_ready(host_in_ready), .host_in_data(host_in_data), .host_out_valid(host_out_valid),
        .host_out_ready(host_out_ready), .host_out_data(host_out_data), .link_out_valid(link_out_valid),
        .link_out_ready(link_out_ready), .link_out_data(link_out_data), .link_in_valid(link_in_valid),
        .link_in_ready(link_in_ready), .link_in(link_in), .dial_query_addr(dial_query_addr),
        .dial_addr_present(dial_addr_present), .link_open(link_open), .link_addr(link_addr),
        .rtu_poll_enable(rtu_poll_enable));

    mci_host_model u_host (.sys_clk(sys_clk), .host_in_valid(host_in_valid), .host_in_ready(host_in_ready),
        .host_in_data(host_in_data), .host_out_ready(host_out_ready), .stall_en(stall_en));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // checking
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge sys_clk) begin
        if (sys_rst === 1'b0 && host_out_valid === 1'b1 && host_out_ready === 1'b1) begin
            chk("host_out_data", exp_host.size() > 0 ? exp_host.pop_front() : 8'hxx, host_out_data);
        end
        if (sys_rst === 1'b0 && link_out_valid === 1'b1 && link_out_ready === 1'b1) begin
            chk("link_out_data", exp_link.size() > 0 ? exp_link.pop_front() : 8'hxx, link_out_data);
        end
    end

    // the fifo drain side stalls at random in lo_mode 1, holds off in 0
    always begin
        @(posedge sys_clk);
        #1;
        link_out_ready = lo_mode ? 1'($urandom % 2) : 1'b0;
    end

    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic string rsp(input int code);
        string t;
        if (verb_num != 0) t = $sformatf("%0d", code);
        else t = (code == 0) ? "OK" : (code == 1) ? "CONNECT" : "ERROR";
        return {t, "\015"};
    endfunction

    task automatic push(input string t, input bit to_link);
        for (int i = 0; i < t.len(); i++) begin
            if (to_link) exp_link.push_back(t[i]);
            else exp_host.push_back(t[i]);
        end
    endtask

    task automatic drain;
        int n;
        n = 0;
        while ((exp_host.size() > 0 || exp_link.size() > 0) && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 3000) chk("queues drained", 0, 1);
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    // echo of the line first, then the reply; code -1 means no reply
    task automatic cmd(input string t, input int code);
        push({t, "\015"}, 0);
        if (code >= 0) push(rsp(code), 0);
        u_host.send_line(t);
        drain();
    endtask

    task automatic remote(input logic [ADDR_W-1:0] src, input logic [7:0] d, input bit fwd);
        @(posedge sys_clk);
        #1;
        if (fwd) exp_host.push_back(d);
        link_in_valid = 1'b1;
        link_in = '{src: src, data: d};
        do @(posedge sys_clk); while (link_in_ready !== 1'b1);
        #1;
        link_in_valid = 1'b0;
        link_in.data = ~d;
        drain();
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hf134));
        n_mismatch = 0;
        checks_done = 0;
        verb_num = 0;
        sys_rst = 1'b1;
        is_master = 1'b1;
        dialup_emulation_enable = 1'b1;
        stall_en = 1'b1;
        lo_mode = 1'b1;
        known_addr = 17'h0_04D2;
        link_in_valid = 1'b0;
        link_in = '0;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("link_open in reset", 0, link_open);
        chk("poll enable idle", 0, rtu_poll_enable);
        sys_rst = 1'b0;
        cmd("AT", 0);
        // the reply to a verbosity change already uses the new form
        verb_num = 1;
        cmd("ATV0", 0);
        cmd("AT", 0);
        cmd("ATQ", 4);
        cmd("ATDT0123456", 4);
        verb_num = 0;
        cmd("ATV1", 0);
        cmd("ATH", 0);
        cmd("ATZ", 4);
        cmd("xyAT", -1);
        cmd($sformatf("ATDT%05d", 77), 1);
        chk("link_open unknown", 0, link_open);
        cmd($sformatf("ATDT%05d", known_addr), 1);
        chk("link_open", 1, link_open);
        chk("link_addr", known_addr, link_addr);
        chk("poll enable linked", 1, rtu_poll_enable);
        // fill the fifo until it refuses, then drain it
        lo_mode = 1'b0;
        s = "";
        for (int i = 0; i < 20; i++) s = {s, string'(8'h61 + 8'($urandom % 26))};
        push(s, 1);
        fork
            u_host.send_str(s);
            begin
                repeat (80) @(posedge sys_clk);
                #1;
                chk("input refused when full", 0, host_in_ready);
                chk("fifo not empty", 1, link_out_valid);
                lo_mode = 1'b1;
            end
        join
        drain();
        push("+a++b", 1);
        u_host.send_str("+a++b");
        drain();
        remote(known_addr, 8'h72, 1);
        remote(known_addr + 17'h0_0001, 8'h73, 0);
        push(rsp(0), 0);
        u_host.send_str("+++");
        drain();
        chk("link closed by escape", 0, link_open);
        // raw mode: no commands, everything flows through
        is_master = 1'b0;
        repeat (3) @(posedge sys_clk);
        push("AT\015", 1);
        u_host.send_line("AT");
        drain();
        // master again, but emulation switched off: still raw
        is_master = 1'b1;
        dialup_emulation_enable = 1'b0;
        remote(17'h0_0005, 8'h71, 1);
        chk("poll enable raw", 1, rtu_poll_enable);
        stop_test();
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end
endmodule // mci_top_tb
